// *** rtl/psc_pkg.sv ***
package psc_pkg;
	localparam int CLK_MHZ = 250;
	// power-on hold
	localparam int POR_MS = 100;
	localparam int POR_CYC = POR_MS * 1000 * CLK_MHZ;
	// config request low to outputs low, longest
	localparam int REQ_LOW_NS = 800;
	localparam int REQ_LOW_CYC = (REQ_LOW_NS * CLK_MHZ) / 1000;
	// status low pulse after request release, least and longest
	localparam int STATUS_MIN_US = 10;
	localparam int STATUS_MAX_US = 40;
	localparam int STATUS_CYC = (STATUS_MIN_US * CLK_MHZ + STATUS_MAX_US * CLK_MHZ) / 2;
	// done high to user mode, internal oscillator
	localparam int UM_MIN_US = 18;
	localparam int UM_MAX_US = 40;
	localparam int UM_CYC = (UM_MIN_US * CLK_MHZ + UM_MAX_US * CLK_MHZ) / 2;
	// user startup clock option
	localparam int USR_EN_PERIODS = 4;
	localparam int USR_UM_PERIODS = 299;
	localparam int CONFIG_CLOCK_MAX_NS = 64;
	localparam int USR_EN_CYC = (USR_EN_PERIODS * CONFIG_CLOCK_MAX_NS * CLK_MHZ) / 1000;
	// bitstream length, default of the top parameter
	localparam int BITS_DEF = 1024;
	localparam int CNT_W = 32;
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
	typedef enum logic [2:0] {
		PSC_POR = 3'b000,
		PSC_RESET = 3'b001,
		PSC_HOLD = 3'b010,
		PSC_LOAD = 3'b011,
		PSC_START = 3'b100,
		PSC_USER = 3'b101,
		PSC_ERROR = 3'b110
	} psc_state_e;
endpackage

// *** rtl/psc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module psc_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// async level in
	input wire logic i_d,
	// filtered level and rising edge
	output logic o_q,
	output logic o_rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic q_r;
	logic q_nxt;
	logic rise_nxt;
	// a change counts only once stages two and three agree
	always_comb begin
		q_nxt = (s2_r == s3_r) ? s3_r : q_r;
		rise_nxt = q_nxt & ~q_r;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			q_r <= 1'b1;
			o_rise <= 1'b0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
			o_rise <= rise_nxt;
		end
	end
	assign o_q = q_r;
endmodule // psc_sync
`default_nettype wire

// *** rtl/psc_config_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
module psc_config_slave
	import psc_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC,
	parameter int BITS = BITS_DEF
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// host link pins
	input wire logic i_config_clock,
	input wire logic i_config_data,
	input wire logic i_config_request_n,
	input wire logic i_chain_enable_in,
	// startup options
	input wire logic i_use_user_clock,
	input wire logic i_user_startup_clock,
	input wire logic i_crc_error,
	// open-drain status: in, out low, enable
	input wire logic i_status_open_drain,
	output logic o_status_open_drain,
	output logic o_status_open_drain_oe,
	// open-drain done
	output logic o_config_done,
	output logic o_config_done_oe,
	// chain, user mode, loaded data
	output logic o_chain_enable_out,
	output logic o_user_startup_enable,
	output logic o_user_mode,
	output logic o_store_we,
	output logic o_store_bit
);
	import psc_pkg::*;

	logic clk_q, clk_rise, dat_q, req_q, ce_q, st_q, uclk_q, uclk_rise;
	psc_state_e state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [CNT_W-1:0] bits_r, bits_nxt;
	logic drv_st_nxt, drv_cd_nxt, ceo_nxt, uen_nxt, um_nxt, we_nxt, bit_nxt;

	// every pin but the crc error and the user clock option passes the three-stage filter, the link clock included
	psc_sync u_clk (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_config_clock),
		.o_q(clk_q), .o_rise(clk_rise));
	psc_sync u_dat (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_config_data),
		.o_q(dat_q), .o_rise());
	psc_sync u_req (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_config_request_n),
		.o_q(req_q), .o_rise());
	psc_sync u_ce (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_chain_enable_in),
		.o_q(ce_q), .o_rise());
	psc_sync u_st (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_status_open_drain),
		.o_q(st_q), .o_rise());
	psc_sync u_uclk (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_user_startup_clock),
		.o_q(uclk_q), .o_rise(uclk_rise));

	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
		dec = (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
	endfunction

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = dec(cnt_r);
		bits_nxt = bits_r;
		we_nxt = 1'b0;
		bit_nxt = o_store_bit;
		case (state_r)
			PSC_POR: begin
				if (cnt_r == CNT_ZERO) begin
					state_nxt = PSC_HOLD;
					cnt_nxt = CNT_ZERO;
				end
			end
			PSC_RESET: begin
				// status stays low while the host keeps the request low
				if (req_q) begin
					state_nxt = PSC_HOLD;
					cnt_nxt = CNT_W'(STATUS_CYC);
				end
			end
			PSC_HOLD: begin
				// status is released first; loading waits for the wired line to read high
				// so our own low level is never taken for an outside error
				if (cnt_r == CNT_ZERO && st_q) begin
					state_nxt = PSC_LOAD;
					bits_nxt = CNT_ZERO;
				end
			end
			PSC_LOAD: begin
				// loading only while our chain enable is low
				if (!ce_q && clk_rise) begin
					we_nxt = 1'b1;
					bit_nxt = dat_q;
					bits_nxt = bits_r + CNT_ONE;
				end
				if (i_crc_error || !st_q) begin
					state_nxt = PSC_ERROR;
				end else if (bits_r == CNT_W'(BITS)) begin
					state_nxt = PSC_START;
					cnt_nxt = i_use_user_clock ? CNT_W'(USR_EN_CYC) : CNT_W'(UM_CYC);
					bits_nxt = CNT_W'(USR_UM_PERIODS);
				end
			end
			PSC_START: begin
				if (!st_q) begin
					state_nxt = PSC_ERROR;
				end else if (!i_use_user_clock) begin
					if (cnt_r == CNT_ZERO) state_nxt = PSC_USER;
				end else if (cnt_r == CNT_ZERO) begin
					// count user clock periods once enabled
					if (uclk_rise) bits_nxt = dec(bits_r);
					if (bits_r == CNT_ZERO) state_nxt = PSC_USER;
				end
			end
			PSC_USER: ;
			PSC_ERROR: ;
			default: state_nxt = PSC_ERROR;
		endcase
		// request low overrides all but the power-on hold
		if (!req_q && state_r != PSC_POR) begin
			state_nxt = PSC_RESET;
			cnt_nxt = CNT_ZERO;
		end
		// no bit is stored in the cycle that leaves loading
		we_nxt = we_nxt && (state_nxt == PSC_LOAD);
		drv_st_nxt = (state_nxt == PSC_POR) || (state_nxt == PSC_RESET) ||
			((state_nxt == PSC_HOLD) && (cnt_nxt != CNT_ZERO)) ||
			(state_nxt == PSC_ERROR);
		drv_cd_nxt = (state_nxt != PSC_START) && (state_nxt != PSC_USER);
		ceo_nxt = ~((state_nxt == PSC_START) || (state_nxt == PSC_USER));
		uen_nxt = (state_nxt == PSC_START) && i_use_user_clock && (cnt_nxt == CNT_ZERO);
		um_nxt = (state_nxt == PSC_USER);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= PSC_POR;
			cnt_r <= CNT_W'(POR_CYCLES);
			bits_r <= CNT_ZERO;
			o_status_open_drain_oe <= 1'b1;
			o_config_done_oe <= 1'b1;
			o_chain_enable_out <= 1'b1;
			o_user_startup_enable <= 1'b0;
			o_user_mode <= 1'b0;
			o_store_we <= 1'b0;
			o_store_bit <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			bits_r <= bits_nxt;
			o_status_open_drain_oe <= drv_st_nxt;
			o_config_done_oe <= drv_cd_nxt;
			o_chain_enable_out <= ceo_nxt;
			o_user_startup_enable <= uen_nxt;
			o_user_mode <= um_nxt;
			o_store_we <= we_nxt;
			o_store_bit <= bit_nxt;
		end
	end
	// open-drain pins only ever drive low
	assign o_status_open_drain = 1'b0;
	assign o_config_done = 1'b0;
endmodule // psc_config_slave
`default_nettype wire

// *** tb/psc_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module psc_chk (
	// watched ports
	input wire logic i_clk, i_rst, i_config_request_n, i_use_user_clock,
	input wire logic o_status_open_drain, o_status_open_drain_oe, o_config_done,
	input wire logic o_config_done_oe, o_chain_enable_out, o_user_startup_enable,
	input wire logic o_user_mode, o_store_we
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	// age of the released done line, saturates so a long user mode never wraps
	always_comb cnt_nxt = o_config_done_oe ? 16'h0000 : cnt_r + {15'h0000, ~&cnt_r};
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) cnt_r <= 16'h0000;
		else cnt_r <= cnt_nxt;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_od_data_low: assert property (!o_status_open_drain && !o_config_done)
		else $error("open-drain data driven high");
	a_req_clears: assert property ($fell(i_config_request_n) |-> ##[1:200]
		(o_status_open_drain_oe && o_config_done_oe && !o_user_mode)) else $error("request ignored");
	a_load_gated: assert property (o_store_we |-> !o_status_open_drain_oe && o_config_done_oe)
		else $error("bit stored outside load");
	a_done_first: assert property (o_user_mode |-> !o_config_done_oe && !o_chain_enable_out)
		else $error("user mode before done");
	a_chain_follow: assert property ($fell(o_config_done_oe) |-> !o_chain_enable_out)
		else $error("chain enable not low at done");
	a_user_holds: assert property (o_user_mode && i_config_request_n &&
		$past(i_config_request_n, 4) |=> o_user_mode) else $error("user mode left without request");
	a_osc_window: assert property ($rose(o_user_mode) && !i_use_user_clock |->
		cnt_r >= 16'h1194 && cnt_r <= 16'h2710) else $error("startup time out of window");
	a_usr_enable: assert property ($rose(o_user_startup_enable) |-> cnt_r <= 16'h0046)
		else $error("user clock enabled late");
endmodule // psc_chk
`default_nettype wire

// *** tb/psc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module psc_host (
	input wire logic i_clk,
	output logic o_config_clock,
	output logic o_config_data,
	output logic o_config_request_n
);
	initial begin
		o_config_clock = 1'b0;
		o_config_data = 1'b0;
		o_config_request_n = 1'b1;
	end
	// 2.4 us low, above the least pulse
	task request();
		@(posedge i_clk) #1 o_config_request_n = 1'b0;
		repeat (600) @(posedge i_clk);
		#1 o_config_request_n = 1'b1;
	endtask
	// msb first; clock stands low between frames, data flips so no stale bit shows
	task send(input logic [15:0] v);
		for (int i = 15; i >= 0; i--) begin
			#1 o_config_data = v[i];
			#31 o_config_clock = 1'b1;
			#32 o_config_clock = 1'b0;
		end
		o_config_data = ~o_config_data;
	endtask
endmodule // psc_host
`default_nettype wire

// *** tb/psc_config_slave_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module psc_config_slave_tb_top;
	logic clk = 1'b0, rst = 1'b1, chain_n = 1'b1, use_usr = 1'b0, usr_clk = 1'b0;
	logic crc = 1'b0, pull = 1'b0, config_clock, dat, req_n, st_oe, st_d, dn, dn_oe, chain_o;
	logic usr_en, um, we, sbit;
	logic [15:0] cap = 16'h0000;
	int nbits = 0, err_count = 0, num_checks = 0;
	wire logic st_w;
	assign st_w = !(st_oe || pull);
	always #2 clk = ~clk;
	// offset by 1 ns so user clock edges never meet a system clock edge
	initial begin
		#1;
		forever #10 usr_clk = ~usr_clk;
	end
	always @(posedge clk) if (we) begin
		cap <= {cap[14:0], sbit};
		nbits <= nbits + 1;
	end
	psc_host host_u (.i_clk(clk), .o_config_clock(config_clock), .o_config_data(dat),
		.o_config_request_n(req_n));
	psc_config_slave #(.POR_CYCLES(50), .BITS(16)) dut_u (.i_clk(clk), .i_rst(rst),
		.i_config_clock(config_clock), .i_config_data(dat), .i_config_request_n(req_n),
		.i_chain_enable_in(chain_n), .i_use_user_clock(use_usr),
		.i_user_startup_clock(usr_clk), .i_crc_error(crc), .i_status_open_drain(st_w),
		.o_status_open_drain(st_d), .o_status_open_drain_oe(st_oe), .o_config_done(dn),
		.o_config_done_oe(dn_oe), .o_chain_enable_out(chain_o),
		.o_user_startup_enable(usr_en), .o_user_mode(um), .o_store_we(we), .o_store_bit(sbit));
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task t_load(input logic u, input logic [15:0] v);
		int k;
		use_usr = u;
		host_u.request();
		cyc(10050);
		chk("released", 16'(st_oe), 16'h0000);
		nbits = 0;
		host_u.send(v);
		cyc(10);
		chk("bits", cap, v);
		chk("count", 16'(nbits), 16'h0010);
		chk("done", 16'(dn_oe), 16'h0000);
		chk("chain", 16'(chain_o), 16'h0000);
		cyc(60);
		chk("usr en", 16'(usr_en), 16'(u));
		for (k = 0; k < 12000 && um !== 1'b1; k++) cyc(1);
		chk("user", 16'(um), 16'h0001);
		pull = 1'b1;
		cyc(50);
		chk("kept", 16'(um), 16'h0001);
		pull = 1'b0;
		$display("load done");
	endtask
	task t_err(input logic k);
		host_u.request();
		cyc(10050);
		pull = k;
		crc = ~k;
		cyc(20);
		pull = 1'b0;
		crc = 1'b0;
		nbits = 0;
		host_u.send(16'hFFFF);
		cyc(10);
		chk("err status", 16'(st_oe), 16'h0001);
		chk("err bits", 16'(nbits), 16'h0000);
		chk("err done", 16'(dn_oe), 16'h0001);
		chk("od data", 16'({st_d, dn}), 16'h0000);
		$display("error done");
	endtask
	initial begin
		cyc(3);
		rst = 1'b0;
		cyc(40);
		chk("por hold", 16'(st_oe), 16'h0001);
		cyc(40);
		chk("por end", 16'(st_oe), 16'h0000);
		nbits = 0;
		host_u.send(16'hA5A5);
		cyc(10);
		chk("refused", 16'(nbits), 16'h0000);
		chain_n = 1'b0;
		$display("power-on done");
		t_load(1'b0, 16'hC3A5);
		t_err(1'b0);
		t_err(1'b1);
		t_load(1'b1, 16'h5A3C);
		end_sim();
	end
endmodule // psc_config_slave_tb_top
bind psc_config_slave psc_chk chk_u (.i_clk, .i_rst, .i_config_request_n, .i_use_user_clock,
	.o_status_open_drain, .o_status_open_drain_oe, .o_config_done, .o_config_done_oe,
	.o_chain_enable_out, .o_user_startup_enable, .o_user_mode, .o_store_we);
`default_nettype wire
